// >>> core/cpuit_decoder.sv
// instruction fetch sequencer and timing decoder for the pipelined 8-bit core
`timescale 1ns/1ps
module cpuit_decoder
    import cpuit_pkg::*;
(
    input  wire logic             CORE_CLK_IN,        // core clock, 40 MHz
    input  wire logic             RESETN_IN,          // synchronous reset, active low
    input  wire logic [7:0]       CODE_BYTE_IN,       // code byte from program memory
    input  wire logic             CODE_VALID_IN,      // code byte present this cycle
    input  wire logic [1:0]       BANK_SEL_IN,        // selected register bank
    input  wire logic [7:0]       RI_VALUE_IN,        // contents of the addressed R0/R1
    input  wire logic [15:0]      DATA_POINTER_16_VALUE_IN,      // data_pointer_16 contents
    input  wire logic [7:0]       ACC_VALUE_IN,       // accumulator contents
    input  wire logic             FLASH_WRITE_EN_IN,  // flash write enable from core control
    input  wire logic             FLASH_ERASE_EN_IN,  // flash erase enable from core control
    output logic                  FETCH_REQ_OUT,      // asks for a code byte this cycle
    output logic                  RETIRE_OUT,         // one-cycle pulse, instruction done
    output logic [7:0]            RETIRE_OPCODE_OUT,  // opcode just retired
    output logic [7:0]            RETIRE_OPERAND1_OUT, // first operand byte
    output logic [7:0]            RETIRE_OPERAND2_OUT, // second operand byte
    output logic [LEN_W-1:0]      RETIRE_BYTES_OUT,   // length in code bytes
    output logic [CYC_W-1:0]      RETIRE_CYCLES_OUT,  // tabulated clock count
    output logic [CYC_W-1:0]      RETIRE_ELAPSED_OUT, // clocks actually spent
    output logic                  DIRECT_VALID_OUT,   // first operand is a direct address
    output logic                  DIRECT_IS_SFR_OUT,  // first operand selects sfr space
    output logic                  DEST_IS_SFR_OUT,    // second operand selects sfr space
    output logic                  INDIRECT_VALID_OUT, // instruction uses an indirect operand
    output logic [4:0]            INDIRECT_REG_OUT,   // internal RAM address of R0/R1
    output logic                  EXT_READ_OUT,       // pulse, external data space read
    output logic                  EXT_WRITE_OUT,      // pulse, external data space write
    output logic                  FLASH_WRITE_OUT,    // pulse, program flash byte write
    output logic                  FLASH_ERASE_OUT,    // pulse, program flash sector erase
    output logic [15:0]           EXT_ADDR_OUT,       // external or flash address
    output logic [7:0]            EXT_WDATA_OUT       // data for external or flash write
);
    cpuit_state_t     state_reg;        // waiting for opcode or executing
    logic [7:0]       opcode_reg;       // opcode under execution
    logic [7:0]       operand1_reg;     // first operand byte
    logic [7:0]       operand2_reg;     // second operand byte
    logic [LEN_W-1:0] taken_reg;        // code bytes taken so far
    logic [CYC_W-1:0] elapsed_reg;      // clocks since the opcode was taken
    logic [LEN_W-1:0] len_w;            // tabulated length from the table
    logic [CYC_W-1:0] cyc_w;            // tabulated clocks from the table
    logic             dir_w;            // direct operand flag from the table
    logic             want_opcode;      // sequencer ready for a new opcode
    logic             want_operand;     // sequencer still owes operand bytes
    logic             take_opcode;      // opcode accepted at this edge
    logic             take_operand;     // operand accepted at this edge
    logic             finish_w;         // last clock of the current instruction
    logic             is_xrd;           // external read opcode
    logic             is_xwr;           // external write opcode
    logic             is_xri;           // external move through R0/R1

    // one space or the other, split by the top address bit
    function automatic logic is_sfr(input logic [7:0] addr);
        return addr[SFR_SEL_BIT];
    endfunction : is_sfr

    // indirect RAM forms share the low nibble 6/7 in every group that has them
    function automatic logic uses_ind(input logic [7:0] op);
        return (op[3:1] == 3'b011) && (op[7:4] != 4'h7 || op[3:0] != 4'h5) &&
               (op[7:4] != 4'h8 && op[7:4] != 4'ha ? 1'b1 : op[3:1] == 3'b011);
    endfunction : uses_ind

    // timing table lives in its own small lookup
    cpuit_timing_rom u_rom (
        .clk_in     (CORE_CLK_IN),
        .rst_n_in   (RESETN_IN),
        .en_in      (take_opcode),
        .opcode_in  (CODE_BYTE_IN),
        .bytes_out  (len_w),
        .cycles_out (cyc_w),
        .direct_out (dir_w)
    );

    // an instruction ends only when its bytes are in and its clocks are spent
    // table answers arrive one clock after the opcode
    assign finish_w     = (state_reg == ST_EXEC) && (taken_reg >= len_w) &&
                          (elapsed_reg >= cyc_w);
    assign want_opcode  = (state_reg == ST_OPCODE) || finish_w;
    assign want_operand = (state_reg == ST_EXEC) && (taken_reg < len_w);
    assign take_opcode  = want_opcode && CODE_VALID_IN;
    assign take_operand = want_operand && CODE_VALID_IN;
    assign FETCH_REQ_OUT = want_opcode || want_operand;

    // external data move decode, same encodings as the standard instruction set
    assign is_xrd = (opcode_reg == OP_XRD_DATA_POINTER_16) || (opcode_reg == OP_XRD_R0) ||
                    (opcode_reg == OP_XRD_R1);
    assign is_xwr = (opcode_reg == OP_XWR_DATA_POINTER_16) || (opcode_reg == OP_XWR_R0) ||
                    (opcode_reg == OP_XWR_R1);
    assign is_xri = (is_xrd || is_xwr) && (opcode_reg != OP_XRD_DATA_POINTER_16) &&
                    (opcode_reg != OP_XWR_DATA_POINTER_16);

    // sequencer state
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RESETN_IN)
            state_reg <= ST_OPCODE;
        else
        begin
            unique case (state_reg)
                ST_OPCODE:
                    if (take_opcode)
                        state_reg <= ST_EXEC;
                ST_EXEC:
                    if (finish_w && !take_opcode)
                        state_reg <= ST_OPCODE;   // code bus dry, wait idle
            endcase
        end
    end

    // opcode and operand capture
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            opcode_reg   <= BYTE_ZERO;
            operand1_reg <= BYTE_ZERO;
            operand2_reg <= BYTE_ZERO;
        end
        else if (take_opcode)
        begin
            opcode_reg   <= CODE_BYTE_IN;
            operand1_reg <= BYTE_ZERO;
            operand2_reg <= BYTE_ZERO;
        end
        else if (take_operand)
        begin
            if (taken_reg == LEN_1)
                operand1_reg <= CODE_BYTE_IN;
            else
                operand2_reg <= CODE_BYTE_IN;
        end
    end

    // byte count and clock count; a stalled code bus only lengthens the instruction
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            taken_reg   <= LEN_1;
            elapsed_reg <= CYC_1;
        end
        else if (take_opcode)
        begin
            taken_reg   <= LEN_1;
            elapsed_reg <= CYC_1;
        end
        else if (state_reg == ST_EXEC)
        begin
            if (take_operand)
                taken_reg <= taken_reg + LEN_1;
            if (elapsed_reg != CYC_MAX)
                elapsed_reg <= elapsed_reg + CYC_1;   // saturates, never wraps
        end
    end

    // retire record and operand space decode, all from flip-flops
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            RETIRE_OUT          <= 1'b0;
            RETIRE_OPCODE_OUT   <= BYTE_ZERO;
            RETIRE_OPERAND1_OUT <= BYTE_ZERO;
            RETIRE_OPERAND2_OUT <= BYTE_ZERO;
            RETIRE_BYTES_OUT    <= LEN_1;
            RETIRE_CYCLES_OUT   <= CYC_1;
            RETIRE_ELAPSED_OUT  <= CYC_1;
            DIRECT_VALID_OUT    <= 1'b0;
            DIRECT_IS_SFR_OUT   <= 1'b0;
            DEST_IS_SFR_OUT     <= 1'b0;
            INDIRECT_VALID_OUT  <= 1'b0;
            INDIRECT_REG_OUT    <= IND_ZERO;
        end
        else
        begin
            RETIRE_OUT <= finish_w;
            if (finish_w)
            begin
                RETIRE_OPCODE_OUT   <= opcode_reg;
                RETIRE_OPERAND1_OUT <= operand1_reg;
                RETIRE_OPERAND2_OUT <= operand2_reg;
                RETIRE_BYTES_OUT    <= len_w;
                RETIRE_CYCLES_OUT   <= cyc_w;
                RETIRE_ELAPSED_OUT  <= elapsed_reg;
                DIRECT_VALID_OUT    <= dir_w;
                DIRECT_IS_SFR_OUT   <= dir_w && is_sfr(operand1_reg);
                DEST_IS_SFR_OUT     <= dir_w && is_sfr(operand2_reg);
                INDIRECT_VALID_OUT  <= uses_ind(opcode_reg) || is_xri;
                // bank base plus R0/R1 gives the internal RAM byte holding the pointer
                INDIRECT_REG_OUT    <= {BANK_SEL_IN, RI_PAD, opcode_reg[RI_SEL_BIT]};
            end
        end
    end

    // external data moves; a write with flash enabled lands in program flash instead
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            EXT_READ_OUT    <= 1'b0;
            EXT_WRITE_OUT   <= 1'b0;
            FLASH_WRITE_OUT <= 1'b0;
            FLASH_ERASE_OUT <= 1'b0;
            EXT_ADDR_OUT    <= ADDR_ZERO;
            EXT_WDATA_OUT   <= BYTE_ZERO;
        end
        else
        begin
            EXT_READ_OUT    <= finish_w && is_xrd;
            EXT_WRITE_OUT   <= finish_w && is_xwr && !FLASH_WRITE_EN_IN;
            FLASH_WRITE_OUT <= finish_w && is_xwr && FLASH_WRITE_EN_IN &&
                               !FLASH_ERASE_EN_IN;
            // erase needs both enables high
            FLASH_ERASE_OUT <= finish_w && is_xwr && FLASH_WRITE_EN_IN &&
                               FLASH_ERASE_EN_IN;
            if (finish_w && (is_xrd || is_xwr))
            begin
                EXT_ADDR_OUT  <= is_xri ? {BYTE_ZERO, RI_VALUE_IN} : DATA_POINTER_16_VALUE_IN;
                EXT_WDATA_OUT <= ACC_VALUE_IN;
            end
        end
    end

    // checks
    // opcode taken off the code bus
    sequence s_take(logic [7:0] op);
        take_opcode && (CODE_BYTE_IN == op);
    endsequence

    // opcode reported as retired
    sequence s_retire(logic [7:0] op);
        RETIRE_OUT && (RETIRE_OPCODE_OUT == op);
    endsequence

    // core clock, quiet during reset
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RESETN_IN);

    a_add_with_carry_reg_one: assert property (s_take(OP_ADD_WITH_CARRY_R0) |=> finish_w)
        else $error("add_with_carry register did not end after one clock");

    a_add_ind_two: assert property (s_take(OP_ADD_IR0) |=> !finish_w ##1 finish_w)
        else $error("add indirect did not end after two clocks");

    a_add_with_carry_imm_len: assert property (s_retire(OP_ADD_WITH_CARRY_IMM) |->
            RETIRE_BYTES_OUT == LEN_2 && RETIRE_CYCLES_OUT == CYC_2)
        else $error("add_with_carry immediate length or timing wrong");

    a_subtract_with_borrow_dir_len: assert property (s_retire(OP_SUBTRACT_WITH_BORROW_DIR) |->
            RETIRE_BYTES_OUT == LEN_2 && RETIRE_ELAPSED_OUT >= CYC_2)
        else $error("subtract_with_borrow direct length or timing wrong");

    a_rotate_one: assert property ((s_take(OP_RLC) or s_take(OP_RRC)) |=>
            finish_w ##1 RETIRE_CYCLES_OUT == CYC_1)
        else $error("rotate through carry not one clock");

    a_three_byte: assert property ((s_retire(OP_MOV_DD) or s_retire(OP_MOV_DATA_POINTER_16)) |->
            RETIRE_BYTES_OUT == LEN_3 && RETIRE_CYCLES_OUT == CYC_3)
        else $error("three byte move length or timing wrong");

    a_code_move: assert property ((s_take(OP_CODE_DATA_POINTER_16) or s_take(OP_CODE_PC)) |=>
            !finish_w [*2] ##1 finish_w)
        else $error("code_byte_move not three clocks");

    a_stack_len: assert property ((s_retire(OP_PUSH) or s_retire(OP_POP)) |->
            RETIRE_BYTES_OUT == LEN_2 && RETIRE_CYCLES_OUT == CYC_2)
        else $error("stack move length or timing wrong");

    a_full_count: assert property (RETIRE_OUT |->
            RETIRE_ELAPSED_OUT >= RETIRE_CYCLES_OUT)
        else $error("instruction retired before its clock count");

    a_no_early_fetch: assert property ((state_reg == ST_EXEC && !finish_w) |->
            !take_opcode)
        else $error("opcode taken while instruction still running");

    a_flash_write: assert property ($rose(FLASH_WRITE_OUT) |->
            $past(is_xwr) && $past(FLASH_WRITE_EN_IN) && !EXT_WRITE_OUT)
        else $error("flash write without enabled external write");

    a_sfr_split: assert property ((RETIRE_OUT && DIRECT_VALID_OUT) |->
            DIRECT_IS_SFR_OUT == RETIRE_OPERAND1_OUT[SFR_SEL_BIT])
        else $error("direct address space decode wrong");

    a_ext_timing: assert property ((EXT_READ_OUT || EXT_WRITE_OUT || FLASH_WRITE_OUT) |->
            RETIRE_OUT && RETIRE_BYTES_OUT == LEN_1 && RETIRE_CYCLES_OUT == CYC_3)
        else $error("external move length or timing wrong");

    a_flash_one: assert property (FLASH_ERASE_OUT |->
            !FLASH_WRITE_OUT && !EXT_WRITE_OUT)
        else $error("flash erase overlapped a write");

    a_fetch_shut: assert property ((state_reg == ST_EXEC && taken_reg >= len_w &&
            elapsed_reg < cyc_w) |-> !FETCH_REQ_OUT)
        else $error("fetch open before clock count spent");

    a_one_clock: assert property ((RETIRE_OUT && RETIRE_CYCLES_OUT == CYC_1) |->
            RETIRE_BYTES_OUT == LEN_1)
        else $error("one clock instruction longer than one byte");
endmodule : cpuit_decoder

// >>> core/cpuit_pkg.sv
// constants, encodings and timing figures for the instruction timing decoder
// Operation
// - external data move also writes/erases program flash
// - add_with_carry register: one byte, one cycle
// - add indirect RAM: one byte, two cycles
// - add_with_carry immediate: two bytes, two cycles
// - subtract_with_borrow direct: two bytes, two cycles
// - subtract_with_borrow indirect: one byte, two cycles
// - AND/OR/XOR immediate into direct: three, three
// - XOR indirect into accumulator: one byte, two cycles
// - rotate left through carry: one byte, one cycle
// - rotate right through carry: one byte, one cycle
// - direct to direct move: three bytes, three
// - immediate to indirect RAM: two bytes, two
// - load data_pointer_16 constant: three bytes, three
// - code_byte_move via pointer: one byte, three
// - code_byte_move via PC: one byte, three
// - external_data_move all forms: one byte, three
// - push direct: two bytes, two cycles
// - pop direct: two bytes, two cycles
// - exchange accumulator with indirect: one, two
// - exchange_low_nibble indirect: one byte, two cycles
// - standard opcode encoding, only timing differs
// - direct below 0x80 is RAM, else SFR
// - indirect address from bank register R0/R1
package cpuit_pkg;
    localparam int          LEN_W          = 2;      // width of byte length
    localparam int          CYC_W          = 4;      // width of cycle count
    localparam logic [1:0]  LEN_1          = 2'h1;   // one code byte
    localparam logic [1:0]  LEN_2          = 2'h2;   // two code bytes
    localparam logic [1:0]  LEN_3          = 2'h3;   // three code bytes
    localparam logic [3:0]  CYC_1          = 4'h1;   // one clock
    localparam logic [3:0]  CYC_2          = 4'h2;   // two clocks
    localparam logic [3:0]  CYC_3          = 4'h3;   // three clocks
    localparam logic [3:0]  CYC_4          = 4'h4;   // four clocks
    localparam logic [3:0]  CYC_8          = 4'h8;   // eight clocks
    localparam logic [3:0]  CYC_MAX        = 4'hf;   // elapsed counter saturation
    localparam logic [7:0]  BYTE_ZERO      = 8'h00;  // reset value of byte registers
    localparam logic [15:0] ADDR_ZERO      = 16'h0000; // reset value of addresses
    localparam logic [4:0]  IND_ZERO       = 5'h00;  // reset value of indirect address
    localparam int          SFR_SEL_BIT    = 7;      // direct address bit choosing sfr space
    localparam int          RI_SEL_BIT     = 0;      // opcode bit choosing R0 or R1
    localparam logic [1:0]  RI_PAD         = 2'h0;   // bank offset bits between bank and Ri
    // external data move opcodes
    localparam logic [7:0]  OP_XRD_DATA_POINTER_16    = 8'he0;
    localparam logic [7:0]  OP_XRD_R0      = 8'he2;
    localparam logic [7:0]  OP_XRD_R1      = 8'he3;
    localparam logic [7:0]  OP_XWR_DATA_POINTER_16    = 8'hf0;
    localparam logic [7:0]  OP_XWR_R0      = 8'hf2;
    localparam logic [7:0]  OP_XWR_R1      = 8'hf3;
    // opcodes singled out by the checks
    localparam logic [7:0]  OP_ADD_WITH_CARRY_R0     = 8'h38;
    localparam logic [7:0]  OP_ADD_IR0     = 8'h26;
    localparam logic [7:0]  OP_ADD_WITH_CARRY_IMM    = 8'h34;
    localparam logic [7:0]  OP_SUBTRACT_WITH_BORROW_DIR    = 8'h95;
    localparam logic [7:0]  OP_RLC         = 8'h33;
    localparam logic [7:0]  OP_RRC         = 8'h13;
    localparam logic [7:0]  OP_MOV_DD      = 8'h85;
    localparam logic [7:0]  OP_MOV_DATA_POINTER_16    = 8'h90;
    localparam logic [7:0]  OP_CODE_DATA_POINTER_16   = 8'h93;
    localparam logic [7:0]  OP_CODE_PC     = 8'h83;
    localparam logic [7:0]  OP_PUSH        = 8'hc0;
    localparam logic [7:0]  OP_POP         = 8'hd0;
    // decoder sequencing states
    typedef enum logic [0:0] {ST_OPCODE, ST_EXEC} cpuit_state_t;
endpackage : cpuit_pkg

// >>> core/cpuit_timing_rom.sv
// registered lookup of code length, cycle count and direct-operand flag per opcode
`timescale 1ns/1ps
module cpuit_timing_rom
    import cpuit_pkg::*;
(
    input  wire logic             clk_in,       // core clock
    input  wire logic             rst_n_in,     // synchronous reset, active low
    input  wire logic             en_in,        // load lookup for the opcode being taken
    input  wire logic [7:0]       opcode_in,    // opcode byte on the code bus
    output logic      [LEN_W-1:0] bytes_out,    // instruction length in code bytes
    output logic      [CYC_W-1:0] cycles_out,   // execution time in clocks
    output logic                  direct_out    // first operand is a direct address
);
    logic [LEN_W+CYC_W:0] entry;                // {direct, bytes, cycles}

    // opcode table; anything outside the covered groups defaults to one byte, one clock
    function automatic logic [LEN_W+CYC_W:0] lookup(input logic [7:0] op);
        logic [LEN_W+CYC_W:0] e;
        e = {1'b0, LEN_1, CYC_1};
        casez (op)
            8'h24, 8'h34, 8'h44, 8'h54, 8'h64, 8'h74, 8'h94:
                e = {1'b0, LEN_2, CYC_2};                   // immediate to accumulator
            8'h05, 8'h15, 8'h25, 8'h35, 8'h45, 8'h55, 8'h65, 8'h95, 8'hc5, 8'he5, 8'hf5,
            8'h42, 8'h52, 8'h62, 8'h86, 8'h87, 8'hc0, 8'hd0:
                e = {1'b1, LEN_2, CYC_2};                   // direct forms
            8'h43, 8'h53, 8'h63, 8'h75, 8'h85:
                e = {1'b1, LEN_3, CYC_3};                   // three byte direct
            8'b1000_1???, 8'b1010_1???:
                e = {1'b1, LEN_2, CYC_2};                   // direct to/from register
            8'ha6, 8'ha7:
                e = {1'b1, LEN_2, CYC_2};                   // direct to indirect RAM
            8'b0111_1???, 8'h76, 8'h77:
                e = {1'b0, LEN_2, CYC_2};                   // immediate to register/ind
            8'b0000_011?, 8'b0001_011?, 8'b0010_011?, 8'b0011_011?, 8'b0100_011?,
            8'b0101_011?, 8'b0110_011?, 8'b1001_011?, 8'b1100_011?, 8'b1101_011?,
            8'b1110_011?, 8'b1111_011?:
                e = {1'b0, LEN_1, CYC_2};
            8'h90:
                e = {1'b0, LEN_3, CYC_3};
            8'h83, 8'h93, 8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3:
                e = {1'b0, LEN_1, CYC_3};
            8'ha4:   e = {1'b0, LEN_1, CYC_4};              // multiply
            8'h84:   e = {1'b0, LEN_1, CYC_8};              // divide
            8'hf4:   e = {1'b0, LEN_1, CYC_2};              // complement accumulator
            default: e = {1'b0, LEN_1, CYC_1};              // one-clock forms
        endcase
        return e;
    endfunction : lookup

    assign entry = lookup(opcode_in);

    // read data leave from a register, loaded only when an opcode is taken
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            bytes_out  <= LEN_1;
            cycles_out <= CYC_1;
            direct_out <= 1'b0;
        end
        else if (en_in)
        begin
            direct_out <= entry[LEN_W+CYC_W];
            bytes_out  <= entry[LEN_W+CYC_W-1:CYC_W];
            cycles_out <= entry[CYC_W-1:0];
        end
    end
endmodule : cpuit_timing_rom

// >>> tb/cpu_instruction_timing_test.sv
// self-checking bench for the instruction timing decoder
`timescale 1ns/1ps
module cpu_instruction_timing_test;
    import cpuit_pkg::*;
    logic             CORE_CLK_IN, RESETN_IN, CODE_VALID_IN;    // clock, reset, byte valid
    logic             FLASH_WRITE_EN_IN, FLASH_ERASE_EN_IN;     // flash steering levels
    logic [7:0]       CODE_BYTE_IN, RI_VALUE_IN, ACC_VALUE_IN;  // code and core values
    logic [1:0]       BANK_SEL_IN;                              // register bank
    logic [15:0]      DATA_POINTER_16_VALUE_IN, EXT_ADDR_OUT;              // pointer in, address out
    logic             FETCH_REQ_OUT, RETIRE_OUT, DIRECT_VALID_OUT;
    logic             DIRECT_IS_SFR_OUT, DEST_IS_SFR_OUT, INDIRECT_VALID_OUT;
    logic             EXT_READ_OUT, EXT_WRITE_OUT, FLASH_WRITE_OUT, FLASH_ERASE_OUT;
    logic [7:0]       RETIRE_OPCODE_OUT, RETIRE_OPERAND1_OUT, RETIRE_OPERAND2_OUT, EXT_WDATA_OUT;
    logic [LEN_W-1:0] RETIRE_BYTES_OUT;                         // retired length
    logic [CYC_W-1:0] RETIRE_CYCLES_OUT, RETIRE_ELAPSED_OUT;    // retired timing
    logic [4:0]       INDIRECT_REG_OUT;                         // indirect RAM address
    int               err_total = 0;                            // mismatches seen
    int               samples_checked = 0;                      // comparisons made
    // opcode, length, clocks of each timed instruction
    logic [15:0]      tbl [0:28] = '{16'h3811, 16'h2612, 16'h3422, 16'h9522, 16'h9712,
        16'h5333, 16'h4333, 16'h6333, 16'h6612, 16'h3311, 16'h1311, 16'h8533, 16'h7622,
        16'h9033, 16'h9313, 16'h8313, 16'he013, 16'he213, 16'he313, 16'hf013, 16'hf213,
        16'hf313, 16'hc022, 16'hd022, 16'hc612, 16'hd612, 16'ha414, 16'h8418, 16'hf412};

    cpuit_decoder dut (.CORE_CLK_IN(CORE_CLK_IN), .RESETN_IN(RESETN_IN),
        .CODE_BYTE_IN(CODE_BYTE_IN), .CODE_VALID_IN(CODE_VALID_IN), .BANK_SEL_IN(BANK_SEL_IN),
        .RI_VALUE_IN(RI_VALUE_IN), .DATA_POINTER_16_VALUE_IN(DATA_POINTER_16_VALUE_IN), .ACC_VALUE_IN(ACC_VALUE_IN),
        .FLASH_WRITE_EN_IN(FLASH_WRITE_EN_IN), .FLASH_ERASE_EN_IN(FLASH_ERASE_EN_IN),
        .FETCH_REQ_OUT(FETCH_REQ_OUT), .RETIRE_OUT(RETIRE_OUT),
        .RETIRE_OPCODE_OUT(RETIRE_OPCODE_OUT), .RETIRE_OPERAND1_OUT(RETIRE_OPERAND1_OUT),
        .RETIRE_OPERAND2_OUT(RETIRE_OPERAND2_OUT), .RETIRE_BYTES_OUT(RETIRE_BYTES_OUT),
        .RETIRE_CYCLES_OUT(RETIRE_CYCLES_OUT), .RETIRE_ELAPSED_OUT(RETIRE_ELAPSED_OUT),
        .DIRECT_VALID_OUT(DIRECT_VALID_OUT), .DIRECT_IS_SFR_OUT(DIRECT_IS_SFR_OUT),
        .DEST_IS_SFR_OUT(DEST_IS_SFR_OUT), .INDIRECT_VALID_OUT(INDIRECT_VALID_OUT),
        .INDIRECT_REG_OUT(INDIRECT_REG_OUT), .EXT_READ_OUT(EXT_READ_OUT),
        .EXT_WRITE_OUT(EXT_WRITE_OUT), .FLASH_WRITE_OUT(FLASH_WRITE_OUT),
        .FLASH_ERASE_OUT(FLASH_ERASE_OUT), .EXT_ADDR_OUT(EXT_ADDR_OUT),
        .EXT_WDATA_OUT(EXT_WDATA_OUT));

    // 40 MHz core clock
    initial
    begin
        CORE_CLK_IN = 1'b0;
        forever #12.5 CORE_CLK_IN = ~CORE_CLK_IN;
    end

    // compare one value, count it, report a mismatch at once
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // offer one byte from a falling edge until the decoder has taken it
    task automatic send(input logic [7:0] b);
        int n;
        n = 0;
        CODE_BYTE_IN = b;
        CODE_VALID_IN = 1'b1;
        while (FETCH_REQ_OUT !== 1'b1 && n < 20)
        begin
            @(negedge CORE_CLK_IN);
            n++;
        end
        chk("fetch_req", 16'(FETCH_REQ_OUT), 16'h0001);
        @(negedge CORE_CLK_IN);
    endtask : send

    // feed one instruction with no stalls; fetch must stay shut until its clocks are spent
    task automatic run(input logic [7:0] op, o1, o2, input logic [1:0] len,
                       input logic [3:0] cyc);
        send(op);
        if (len > 2'h1) send(o1);
        if (len > 2'h2) send(o2);
        CODE_VALID_IN = 1'b0;
        for (int k = len; k < cyc; k++)
        begin
            chk("fetch_hold", 16'(FETCH_REQ_OUT), 16'h0000);
            @(negedge CORE_CLK_IN);
        end
        chk("fetch_open", 16'(FETCH_REQ_OUT), 16'h0001);
        @(negedge CORE_CLK_IN);
        chk("retire", 16'(RETIRE_OUT), 16'h0001);
        chk("opcode", 16'(RETIRE_OPCODE_OUT), 16'(op));
        chk("operand1", 16'(RETIRE_OPERAND1_OUT), (len > 2'h1) ? 16'(o1) : 16'h0000);
        chk("operand2", 16'(RETIRE_OPERAND2_OUT), (len > 2'h2) ? 16'(o2) : 16'h0000);
        chk("bytes", 16'(RETIRE_BYTES_OUT), 16'(len));
        chk("cycles", 16'(RETIRE_CYCLES_OUT), 16'(cyc));
        chk("elapsed", 16'(RETIRE_ELAPSED_OUT), 16'(cyc));
    endtask : run

    // every timed opcode, length and clock count from the table
    task automatic t_table;
        for (int i = 0; i < 29; i++)
            run(tbl[i][15:8], 8'h12, 8'h34, tbl[i][5:4], tbl[i][3:0]);
        $display("table test done");
    endtask : t_table

    // direct space split at 0x80 and bank-relative indirect register
    task automatic t_addr;
        BANK_SEL_IN = 2'h2;
        run(OP_MOV_DD, 8'h7f, 8'h80, LEN_3, CYC_3);
        chk("dir_valid", 16'(DIRECT_VALID_OUT), 16'h0001);
        chk("dir_sfr", 16'(DIRECT_IS_SFR_OUT), 16'h0000);
        chk("dest_sfr", 16'(DEST_IS_SFR_OUT), 16'h0001);
        run(8'h27, 8'h00, 8'h00, LEN_1, CYC_2);
        chk("ind_valid", 16'(INDIRECT_VALID_OUT), 16'h0001);
        chk("ind_reg", 16'(INDIRECT_REG_OUT), 16'h0011);
        $display("address test done");
    endtask : t_addr

    // external moves steered to flash write, flash erase, external read and external write
    task automatic t_xmove;
        DATA_POINTER_16_VALUE_IN = 16'h1234;
        ACC_VALUE_IN = 8'h5a;
        RI_VALUE_IN = 8'h44;
        FLASH_WRITE_EN_IN = 1'b1;
        run(OP_XWR_DATA_POINTER_16, 8'h00, 8'h00, LEN_1, CYC_3);
        chk("flash_wr", 16'(FLASH_WRITE_OUT), 16'h0001);
        chk("ext_wr", 16'(EXT_WRITE_OUT), 16'h0000);
        chk("er_idle", 16'(FLASH_ERASE_OUT), 16'h0000);
        chk("addr", EXT_ADDR_OUT, 16'h1234);
        chk("wdata", 16'(EXT_WDATA_OUT), 16'h005a);
        FLASH_ERASE_EN_IN = 1'b1;
        run(OP_XWR_R0, 8'h00, 8'h00, LEN_1, CYC_3);
        chk("flash_er", 16'(FLASH_ERASE_OUT), 16'h0001);
        chk("wr_idle", 16'(FLASH_WRITE_OUT), 16'h0000);
        chk("addr_ri", EXT_ADDR_OUT, 16'h0044);
        run(OP_XRD_R1, 8'h00, 8'h00, LEN_1, CYC_3);
        chk("ext_rd", 16'(EXT_READ_OUT), 16'h0001);
        @(negedge CORE_CLK_IN);
        chk("rd_pulse", 16'(EXT_READ_OUT), 16'h0000);
        FLASH_WRITE_EN_IN = 1'b0;
        run(OP_XWR_R1, 8'h00, 8'h00, LEN_1, CYC_3);
        chk("ext_wr1", 16'(EXT_WRITE_OUT), 16'h0001);
        $display("external move test done");
    endtask : t_xmove

    // counts, verdict and end of run
    task close_out;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    // main sequence: reset for four clocks, then the scenarios
    initial
    begin
        RESETN_IN = 1'b0;
        CODE_VALID_IN = 1'b0;
        CODE_BYTE_IN = 8'h00;
        BANK_SEL_IN = 2'h0;
        RI_VALUE_IN = 8'h00;
        DATA_POINTER_16_VALUE_IN = 16'h0000;
        ACC_VALUE_IN = 8'h00;
        FLASH_WRITE_EN_IN = 1'b0;
        FLASH_ERASE_EN_IN = 1'b0;
        repeat (4) @(negedge CORE_CLK_IN);
        RESETN_IN = 1'b1;
        t_table();
        t_addr();
        t_xmove();
        close_out();
    end

    // watchdog: the scenarios need about 130 clocks
    initial
    begin
        #(25 * 6000);
        err_total++;
        close_out();
    end
endmodule : cpu_instruction_timing_test
